// file: rtl/gpdpe_consts.vh
// Constants for the general-purpose data port: register indices, field widths, reset values.
// Assumes inclusion by the port's design file only.
`ifndef GPDPE_CONSTS_VH
`define GPDPE_CONSTS_VH

// ----------------------------------------
// Register map (word indices on the plain register port)
// ----------------------------------------
`define GPDPE_ADDR_W 4
`define GPDPE_IDX_DATA_HIGH 4'h0
`define GPDPE_IDX_DATA_LOW 4'h1
`define GPDPE_IDX_D_DATA_LOW 4'h2

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define GPDPE_PINS_E 25
`define GPDPE_PINS_D 8
`define GPDPE_HIGH_BITS 9
`define GPDPE_HIGH_LSB 16
`define GPDPE_REG_W 16
`define GPDPE_RST_DATA_HIGH 16'h0000
`define GPDPE_RST_DATA_LOW 16'h0000
`define GPDPE_RST_D_DATA_LOW 16'h0000

`endif

// file: rtl/gpdpe_data_port.v
// Data registers of a 25-pin port plus the 8-pin companion port, with per-pin
// input/output/other-function behaviour and the watchdog power-on glitch cycle.
// Assumes pin modes come from outside, pin levels are synchronous to sys_clk.
//
// Contract
// R01 - The port has 25 two-way pins, each with one data bit split over a high and a low register.
// R02 - Low register bits 15..0 map to pins 15..0 and high register bits 8..0 to pins 24..16.
// R03 - Both data registers are 16 bits wide and readable and writable by software.
// R04 - For a pin in general output mode a written data bit is driven onto the pin at once.
// R05 - For a pin in output or other-function mode a read returns the stored bit, not the pin.
// R06 - For a pin in general input mode a read returns the sampled pin level.
// R07 - For a pin in input or other-function mode a write updates the stored bit but not the pin.
// R08 - High register bits 15..9 always read zero and software must write them as zero.
// R09 - The 8-pin companion port bits 7..0 follow the same read and write behaviour.
// R10 - After a watchdog power-on reset, other-function pins drive their data bits for one cycle.
// R11 - That one-cycle drive does not happen after a power-on reset from the external reset pin.
// R12 - Software must set the data bits of strobe pins to the strobe's inactive level.
// R13 - Each pin's mode comes from an outside selection: 0 input, 1 output, separate other flag.
`timescale 1ns/1ps
`include "gpdpe_consts.vh"

module gpdpe_data_port (
	input wire sys_clk,
	input wire rstn,
	input wire wdt_reset,
	input wire [`GPDPE_ADDR_W-1:0] addr,
	input wire [`GPDPE_REG_W-1:0] wdata,
	input wire wr,
	input wire rd,
	output reg [`GPDPE_REG_W-1:0] rdata,
	input wire [`GPDPE_PINS_E-1:0] pin_e_in,
	output reg [`GPDPE_PINS_E-1:0] pin_e_out,
	output reg [`GPDPE_PINS_E-1:0] pin_e_oe,
	input wire [`GPDPE_PINS_E-1:0] pin_e_dir,
	input wire [`GPDPE_PINS_E-1:0] pin_e_other,
	input wire [`GPDPE_PINS_E-1:0] pin_e_other_oe,
	input wire [`GPDPE_PINS_E-1:0] pin_e_other_out,
	input wire [`GPDPE_PINS_D-1:0] pin_d_in,
	output reg [`GPDPE_PINS_D-1:0] pin_d_out,
	output reg [`GPDPE_PINS_D-1:0] pin_d_oe,
	input wire [`GPDPE_PINS_D-1:0] pin_d_dir,
	input wire [`GPDPE_PINS_D-1:0] pin_d_other,
	input wire [`GPDPE_PINS_D-1:0] pin_d_other_oe,
	input wire [`GPDPE_PINS_D-1:0] pin_d_other_out
);

	// ----------------------------------------
	// Local constants
	// ----------------------------------------
	// Reset images are formed at register width and cut to the pin count on purpose.
	localparam [2*`GPDPE_REG_W-1:0] RST_E_WORD = {`GPDPE_RST_DATA_HIGH, `GPDPE_RST_DATA_LOW};
	localparam [`GPDPE_PINS_E-1:0] RST_E = RST_E_WORD[`GPDPE_PINS_E-1:0];
	localparam [`GPDPE_REG_W-1:0] RST_D_WORD = `GPDPE_RST_D_DATA_LOW;
	localparam [`GPDPE_PINS_D-1:0] RST_D = RST_D_WORD[`GPDPE_PINS_D-1:0];
	localparam HIGH_PAD_W = `GPDPE_REG_W - `GPDPE_HIGH_BITS;
	localparam D_PAD_W = `GPDPE_REG_W - `GPDPE_PINS_D;

	// One-hot states of the reset-cause tracker.
	localparam [1:0] ST_FIRST = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;

	// One-hot register selects; an unmapped index selects nothing.
	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_HIGH = 3'h1;
	localparam [2:0] SEL_LOW = 3'h2;
	localparam [2:0] SEL_D = 3'h4;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [`GPDPE_PINS_E-1:0] data_e_q;
	reg [`GPDPE_PINS_E-1:0] data_e_d;
	reg [`GPDPE_PINS_D-1:0] data_d_q;
	reg [`GPDPE_PINS_D-1:0] data_d_d;
	reg [`GPDPE_PINS_E-1:0] view_e;
	reg [`GPDPE_PINS_D-1:0] view_d;
	reg [`GPDPE_REG_W-1:0] rdata_d;
	reg [`GPDPE_PINS_E-1:0] pin_e_out_d;
	reg [`GPDPE_PINS_E-1:0] pin_e_oe_d;
	reg [`GPDPE_PINS_D-1:0] pin_d_out_d;
	reg [`GPDPE_PINS_D-1:0] pin_d_oe_d;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg glitch_d;
	wire [2:0] wr_sel;
	wire [2:0] rd_sel;
	integer i;
	integer k;
	integer m;
	integer n;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Word index to register select, shared by the write and the read path.
	function [2:0] reg_sel;
		input [`GPDPE_ADDR_W-1:0] a;
		begin
			case (a)
				`GPDPE_IDX_DATA_HIGH: begin
					reg_sel = SEL_HIGH;
				end
				`GPDPE_IDX_DATA_LOW: begin
					reg_sel = SEL_LOW;
				end
				`GPDPE_IDX_D_DATA_LOW: begin
					reg_sel = SEL_D;
				end
				default: begin
					reg_sel = SEL_NONE;
				end
			endcase
		end
	endfunction

	// Read value of one pin: pin level in input mode, stored bit otherwise.
	function rd_bit;
		input dir;
		input other;
		input stored;
		input level;
		begin
			rd_bit = (!other && !dir) ? level : stored; // R05 R06 R13
		end
	endfunction

	// Drive value of one pin; the reset cycle replaces the other function's value.
	function drv_out;
		input other;
		input glitch;
		input stored;
		input other_out;
		begin
			if (other) begin
				drv_out = glitch ? stored : other_out; // R10
			end else begin
				drv_out = stored; // R04
			end
		end
	endfunction

	// Drive enable of one pin; a pin in input mode is never driven.
	function drv_oe;
		input other;
		input glitch;
		input dir;
		input other_oe;
		begin
			if (other) begin
				drv_oe = glitch | other_oe; // R10
			end else begin
				drv_oe = dir; // R07 R13
			end
		end
	endfunction

	// ----------------------------------------
	// Reset cause
	// ----------------------------------------
	// The cause is looked at only at the first edge after release, so the asynchronous
	// reset branch loads constants alone and the drive cycle lasts exactly one clock.
	always @* begin
		state_d = state_q;
		glitch_d = 1'h0;
		case (state_q)
			ST_FIRST: begin
				state_d = ST_RUN;
				glitch_d = wdt_reset; // R10 R11
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_FIRST;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Writes always store whatever the mode; only the pin and read paths look at the mode.
	assign wr_sel = wr ? reg_sel(addr) : SEL_NONE;

	always @* begin
		data_e_d = data_e_q;
		if (wr_sel == SEL_HIGH) begin
			data_e_d[`GPDPE_PINS_E-1:`GPDPE_HIGH_LSB] = wdata[`GPDPE_HIGH_BITS-1:0]; // R02 R03 R08
		end
		if (wr_sel == SEL_LOW) begin
			data_e_d[`GPDPE_HIGH_LSB-1:0] = wdata; // R02 R03 R07
		end
	end

	always @* begin
		data_d_d = data_d_q;
		if (wr_sel == SEL_D) begin
			data_d_d = wdata[`GPDPE_PINS_D-1:0]; // R09
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Input pins are read live, so their levels must already be synchronous to sys_clk.
	assign rd_sel = rd ? reg_sel(addr) : SEL_NONE;

	always @* begin
		view_e = {`GPDPE_PINS_E{1'h0}};
		for (i = 0; i < `GPDPE_PINS_E; i = i + 1) begin
			view_e[i] = rd_bit(pin_e_dir[i], pin_e_other[i], data_e_q[i], pin_e_in[i]); // R05 R06
		end
	end

	always @* begin
		view_d = {`GPDPE_PINS_D{1'h0}};
		for (k = 0; k < `GPDPE_PINS_D; k = k + 1) begin
			view_d[k] = rd_bit(pin_d_dir[k], pin_d_other[k], data_d_q[k], pin_d_in[k]); // R09
		end
	end

	always @* begin
		rdata_d = {`GPDPE_REG_W{1'h0}};
		case (rd_sel)
			SEL_HIGH: begin
				rdata_d = {{HIGH_PAD_W{1'h0}}, view_e[`GPDPE_PINS_E-1:`GPDPE_HIGH_LSB]}; // R08
			end
			SEL_LOW: begin
				rdata_d = view_e[`GPDPE_HIGH_LSB-1:0]; // R02 R03
			end
			SEL_D: begin
				rdata_d = {{D_PAD_W{1'h0}}, view_d}; // R09
			end
			default: begin
				rdata_d = {`GPDPE_REG_W{1'h0}};
			end
		endcase
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Computed from next-state data so a written level reaches the pin with the stored bit.
	always @* begin
		pin_e_out_d = {`GPDPE_PINS_E{1'h0}};
		pin_e_oe_d = {`GPDPE_PINS_E{1'h0}};
		for (m = 0; m < `GPDPE_PINS_E; m = m + 1) begin
			pin_e_out_d[m] = drv_out(pin_e_other[m], glitch_d, data_e_d[m],
				pin_e_other_out[m]); // R01 R04
			pin_e_oe_d[m] = drv_oe(pin_e_other[m], glitch_d, pin_e_dir[m],
				pin_e_other_oe[m]); // R07 R13
		end
	end

	always @* begin
		pin_d_out_d = {`GPDPE_PINS_D{1'h0}};
		pin_d_oe_d = {`GPDPE_PINS_D{1'h0}};
		for (n = 0; n < `GPDPE_PINS_D; n = n + 1) begin
			pin_d_out_d[n] = drv_out(pin_d_other[n], glitch_d, data_d_d[n],
				pin_d_other_out[n]); // R09
			pin_d_oe_d[n] = drv_oe(pin_d_other[n], glitch_d, pin_d_dir[n],
				pin_d_other_oe[n]); // R09
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			data_e_q <= RST_E;
			data_d_q <= RST_D;
		end else begin
			data_e_q <= data_e_d;
			data_d_q <= data_d_d;
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= {`GPDPE_REG_W{1'h0}};
		end else begin
			rdata <= rdata_d;
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin_e_out <= {`GPDPE_PINS_E{1'h0}};
			pin_e_oe <= {`GPDPE_PINS_E{1'h0}};
		end else begin
			pin_e_out <= pin_e_out_d;
			pin_e_oe <= pin_e_oe_d;
		end
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin_d_out <= {`GPDPE_PINS_D{1'h0}};
			pin_d_oe <= {`GPDPE_PINS_D{1'h0}};
		end else begin
			pin_d_out <= pin_d_out_d;
			pin_d_oe <= pin_d_oe_d;
		end
	end

endmodule

// file: sim/gpdpe_data_port_properties.sv
// Checker for the port data block: read answers, pin drive and the reset cycle.
// Assumes it is bound onto gpdpe_data_port with ports matched by name.
`timescale 1ns/1ps
module gpdpe_data_port_properties (
	input wire sys_clk,
	input wire rstn,
	input wire wdt_reset,
	input wire wr,
	input wire rd,
	input wire [3:0] addr,
	input wire [15:0] wdata,
	input wire [15:0] rdata,
	input wire [24:0] pin_e_in,
	input wire [24:0] pin_e_out,
	input wire [24:0] pin_e_oe,
	input wire [24:0] pin_e_dir,
	input wire [24:0] pin_e_other,
	input wire [24:0] pin_e_other_oe,
	input wire [7:0] pin_d_out,
	input wire [7:0] pin_d_dir,
	input wire [7:0] pin_d_other
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_wdt_rel;
		$rose(rstn) && wdt_reset;
	endsequence
	AST_IDLE_RD: assert property (!rd |=> rdata == 16'h0000)
		else $error("read data not zero outside a read");
	AST_HIGH_ZERO: assert property (rd && addr == 4'h0 |=> rdata[15:9] == 7'h00)
		else $error("reserved high bits read nonzero");
	AST_LOW_DRIVE: assert property (wr && addr == 4'h1 |=> ((pin_e_out[15:0] ^ $past(wdata))
		& $past(pin_e_dir[15:0] & ~pin_e_other[15:0])) == 16'h0000) else $error("output pin missed write");
	AST_IN_READ: assert property (rd && addr == 4'h1 |=> ((rdata ^ $past(pin_e_in[15:0]))
		& ~$past(pin_e_dir[15:0] | pin_e_other[15:0])) == 16'h0000) else $error("input pin read wrong");
	AST_IN_NO_DRIVE: assert property ((pin_e_oe & $past(~(pin_e_dir | pin_e_other))) == 25'h0)
		else $error("input pin driven");
	AST_WDT_CYCLE: assert property (s_wdt_rel |=> (pin_e_oe & ~pin_e_out & $past(pin_e_other))
		== $past(pin_e_other)) else $error("no output cycle after watchdog reset");
	AST_OTHER_PASS: assert property (!($rose(rstn) && wdt_reset) |=> ((pin_e_oe
		^ $past(pin_e_other_oe)) & $past(pin_e_other)) == 25'h0) else $error("other enable wrong");
	AST_D_DRIVE: assert property (wr && addr == 4'h2 |=> ((pin_d_out ^ $past(wdata[7:0]))
		& $past(pin_d_dir & ~pin_d_other)) == 8'h00) else $error("companion pin missed write");
endmodule
bind gpdpe_data_port gpdpe_data_port_properties u_chk (
	.sys_clk(sys_clk), .rstn(rstn), .wdt_reset(wdt_reset), .wr(wr), .rd(rd), .addr(addr),
	.wdata(wdata), .rdata(rdata), .pin_e_in(pin_e_in), .pin_e_out(pin_e_out),
	.pin_e_oe(pin_e_oe), .pin_e_dir(pin_e_dir), .pin_e_other(pin_e_other),
	.pin_e_other_oe(pin_e_other_oe), .pin_d_out(pin_d_out), .pin_d_dir(pin_d_dir),
	.pin_d_other(pin_d_other)
);

// file: sim/tb.sv
// Self-checking bench for the port data block.
// Assumes the checker binds itself; the bench drives every pin and mode input.
`timescale 1ns/1ps
module tb;
	logic sys_clk = 0, rstn = 0, wdt_reset = 0, wr = 0, rd = 0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	wire [15:0] rdata;
	logic [24:0] pin_e_in = 25'h0AC35A1, pin_e_dir = 25'h1FFFFFF, pin_e_other = 25'h1FFFFFF;
	logic [24:0] pin_e_other_oe = 25'h0F0F0F0, pin_e_other_out = 25'h1555555;
	wire [24:0] pin_e_out, pin_e_oe;
	logic [7:0] pin_d_in = 8'hC6, pin_d_dir = 8'hFF, pin_d_other = 8'hFF;
	logic [7:0] pin_d_other_oe = 8'h0F, pin_d_other_out = 8'h33;
	wire [7:0] pin_d_out, pin_d_oe;
	int fail_count = 0, checks_done = 0;
	gpdpe_data_port i_dut (
		.sys_clk(sys_clk), .rstn(rstn), .wdt_reset(wdt_reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pin_e_in(pin_e_in), .pin_e_out(pin_e_out),
		.pin_e_oe(pin_e_oe), .pin_e_dir(pin_e_dir), .pin_e_other(pin_e_other),
		.pin_e_other_oe(pin_e_other_oe), .pin_e_other_out(pin_e_other_out),
		.pin_d_in(pin_d_in), .pin_d_out(pin_d_out), .pin_d_oe(pin_d_oe), .pin_d_dir(pin_d_dir),
		.pin_d_other(pin_d_other), .pin_d_other_oe(pin_d_other_oe),
		.pin_d_other_out(pin_d_other_out)
	);
	initial forever #5 sys_clk = ~sys_clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Each access leaves one idle edge so a strobe is never set twice in one step.
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		{addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge sys_clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// Mode inputs reach the pins one edge late, so two edges are allowed.
	task automatic mode(input logic [24:0] d, o);
		@(posedge sys_clk);
		{pin_e_dir, pin_e_other, pin_d_dir, pin_d_other} <= {d, o, d[7:0], o[7:0]};
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic rst(input logic w, input logic [24:0] e);
		@(posedge sys_clk);
		{rstn, wdt_reset} <= {1'b0, w};
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		#1 chk(pin_e_oe, e);
		chk(pin_e_out, w ? 25'h0 : pin_e_other_out);
		@(posedge sys_clk);
		#1 chk(pin_e_oe, pin_e_other_oe);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_out();
		mode(25'h1FFFFFF, 25'h0);
		wreg(4'h1, 16'hA5C3);
		wreg(4'h0, 16'hFFFF);
		wreg(4'h2, 16'h005A);
		chk(pin_e_out, 25'h1FFA5C3);
		chk({pin_e_oe, pin_d_out}, {25'h1FFFFFF, 8'h5A});
		rreg(4'h0, 16'h01FF);
		rreg(4'h1, 16'hA5C3);
		rreg(4'h2, 16'h005A);
		rreg(4'h3, 16'h0000);
	endtask
	task automatic t_in();
		mode(25'h0, 25'h0);
		wreg(4'h1, 16'h3C3C);
		chk({pin_e_oe, pin_d_oe}, 33'h0);
		rreg(4'h1, 16'h35A1);
		rreg(4'h0, 16'h00AC);
		rreg(4'h2, 16'h00C6);
		mode(25'h1FFFFFF, 25'h0);
		chk(pin_e_out, 25'h1FF3C3C);
	endtask
	task automatic t_oth();
		mode(25'h1FFFFFF, 25'h1FFFFFF);
		wreg(4'h1, 16'h0F0F);
		chk({pin_e_oe, pin_e_out}, {pin_e_other_oe, pin_e_other_out});
		chk({pin_d_oe, pin_d_out}, {pin_d_other_oe, pin_d_other_out});
		rreg(4'h1, 16'h0F0F);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		rst(1'b0, pin_e_other_oe);
		t_out();
		t_in();
		t_oth();
		// The bench's strobes are active high, so the cleared data bits are their idle level.
		rst(1'b1, 25'h1FFFFFF);
		rst(1'b0, pin_e_other_oe);
		test_done();
	end
	initial begin
		#20000;
		fail_count++;
		test_done();
	end
endmodule
